//--- hdl/bn_pkg.sv
`default_nettype none
package bn_pkg;
  localparam int MEM_WORDS = 128;
  // ---------------------------------------------------------------
  // byte offsets on the register bus
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_MPRIME = 12'h800;
  localparam logic [11:0] OFF_MODE   = 12'h804;
  localparam logic [11:0] OFF_CLEAN  = 12'h808;
  localparam logic [11:0] OFF_EXPGO  = 12'h80C;
  localparam logic [11:0] OFF_MMGO   = 12'h810;
  localparam logic [11:0] OFF_MULGO  = 12'h814;
  localparam logic [11:0] OFF_IDLE   = 12'h818;
  localparam logic [11:0] OFF_IRQCLR = 12'h81C;
  localparam logic [11:0] OFF_CTIME  = 12'h820;
  localparam logic [11:0] OFF_SRCHEN = 12'h824;
  localparam logic [11:0] OFF_SRCHPS = 12'h828;
  localparam logic [11:0] OFF_IRQEN  = 12'h82C;
  localparam logic [11:0] OFF_DATE   = 12'h830;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        CTIME_RST  = 1'h1;
  localparam logic        SRCHEN_RST = 1'h0;
  localparam logic        IRQEN_RST  = 1'h1;
  // arbitrary version value
  localparam logic [31:0] DATE_RST   = 32'h0000_0001;
  localparam logic [6:0]  CLR_LAST   = 7'h7F;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MEM_M = 2'h0,
    MEM_Z = 2'h1,
    MEM_Y = 2'h2,
    MEM_X = 2'h3
  } memId_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wbReq_t;
endpackage
`default_nettype wire

//--- hdl/big_number_modexp_accel.sv
// What this block does
// - exponentiation start computes X^Y mod M, Montgomery
// - modular lengths 32 to 4096 bits, step 32
// - montgomery constant register is 32 bits
// - four memories of 128 words, LSW first
// - only configured length is used
// - operands X,Y,M and R^2 in Z; start
// - completion sets idle and raises interrupt
// - interrupt enable gates the completion interrupt
// - clear bit drops pending completion interrupt
// - exponentiation keeps Y, M, registers; X, Z overwritten
// - modular multiply start computes X*Y mod M
// - modular multiply overwrites only Z
// - plain multiply gives double-length product
// - plain multiply takes Y from upper Z words
// - product fills n Z words, X kept
// - speed-ups default off; on, time data-dependent
// - search skips exponent bits above position
// - constant-time off skips work on zero bits
// - memory-ready reads 0 until memories cleared
// - completion interrupt enable resets enabled
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module big_number_modexp_accel (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire bn_pkg::wbReq_t wbReq,
  output logic [31:0]         wbDatR,
  output logic                wbAck,
  output logic                irq
);
  typedef enum logic [2:0] {
    E_IDLE = 3'h0, E_Q = 3'h1, E_ROW = 3'h2, E_TAIL = 3'h3,
    E_SUB = 3'h4, E_CHK = 3'h5, E_COPY = 3'h6, E_FIN = 3'h7
  } eng_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_XR = 4'h1, S_ONE = 4'h2, S_SQ = 4'h3, S_MUL = 4'h4,
    S_OUT = 4'h5, S_MM1 = 4'h6, S_MM2 = 4'h7, S_PMUL = 4'h8
  } seq_t;

  logic [31:0] mem [0:3][0:bn_pkg::MEM_WORDS-1];
  logic [31:0] t   [0:bn_pkg::MEM_WORDS];
  logic [31:0] mprime_r, date_r, rdat_r, rdNxt, q_r;
  logic [6:0]  mode_r, clrCnt_r;
  logic [11:0] srchPos_r, bit_r;
  logic [7:0]  i_r, j_r;
  logic [33:0] c_r;
  logic        ct_r, srchEn_r, irqEn_r, irqPend_r, clean_r, ack_r, bw_r;
  eng_t        eState_r;
  seq_t        seq_r;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        access = wbReq.cyc & wbReq.stb;
  wire        wrHit  = access & wbReq.we & ack_r;
  wire        isMem  = ~wbReq.adr[11];
  wire [1:0]  memSel = wbReq.adr[10:9];
  wire [6:0]  memIdx = wbReq.adr[8:2];
  wire [31:0] mask   = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
                        {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
  wire        idle   = seq_r == S_IDLE;
  wire        ready  = idle & clean_r;
  wire        bit0   = wbReq.dat[0] & wbReq.sel[0];

  function automatic logic hit(input logic [11:0] off);
    hit = wrHit && !isMem && wbReq.adr == off;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~mask) | (wbReq.dat & mask);
  endfunction

  wire goExp  = hit(bn_pkg::OFF_EXPGO) & bit0 & ready;
  wire goMm   = hit(bn_pkg::OFF_MMGO) & bit0 & ready;
  wire goMul  = hit(bn_pkg::OFF_MULGO) & bit0 & ready;
  wire clrIrq = hit(bn_pkg::OFF_IRQCLR) & bit0;
  wire memWr  = wrHit & isMem & ready;

  // ---------------------------------------------------------------
  // operand selection per step
  // ---------------------------------------------------------------
  wire mulOp = seq_r == S_PMUL;
  wire bOne  = seq_r == S_ONE || seq_r == S_OUT;
  wire bitY  = mem[bn_pkg::MEM_Y][bit_r[11:5]][bit_r[4:0]];
  wire [1:0] aMem = (seq_r == S_XR || seq_r == S_MM1 || mulOp)
                    ? bn_pkg::MEM_X : bn_pkg::MEM_Z;
  wire [1:0] bMem = (seq_r == S_XR || seq_r == S_SQ || seq_r == S_MM1 || mulOp)
                    ? bn_pkg::MEM_Z
                    : (seq_r == S_MUL ? bn_pkg::MEM_X : bn_pkg::MEM_Y);
  wire [1:0] dMem = seq_r == S_XR ? bn_pkg::MEM_X : bn_pkg::MEM_Z;
  // a zero-bit multiply in constant-time mode runs with no write-back
  wire dEn = !(seq_r == S_MUL && !bitY);
  wire seqOp = !idle;

  // word count: n for modular jobs, half of n for products
  wire [7:0] modeP1  = {1'b0, mode_r} + 8'h01;
  wire [7:0] nW      = mulOp ? {1'b0, modeP1[7:1]} : modeP1;
  wire [7:0] copyLen = mulOp ? {nW[6:0], 1'b0} : nW;
  wire [7:0] nLast   = nW - 8'h01;
  wire [12:0] topAll = {nW, 5'h00} - 13'h0001;
  wire [11:0] topBit = srchEn_r ? srchPos_r : topAll[11:0];

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  wire [7:0]  bIdx  = mulOp ? i_r + nW : i_r;
  wire [31:0] aWord = mem[aMem][j_r[6:0]];
  wire [31:0] bWord = bOne ? {31'h0, i_r == 8'h00}
                           : mem[bMem][bIdx[6:0]];
  wire [31:0] mWord = mem[bn_pkg::MEM_M][j_r[6:0]];
  wire [7:0]  tIdx  = mulOp ? i_r + j_r : j_r;
  wire [7:0]  tWr   = tIdx - {7'h00, !mulOp};
  wire [31:0] tRd   = t[tIdx];
  wire [63:0] prodA = aWord * bWord;
  wire [63:0] prodM = q_r * mWord;
  wire [65:0] sum   = 66'(tRd) + 66'(prodA) + 66'(prodM) + 66'(c_r);
  wire [33:0] tail  = 34'(tRd) + c_r;
  wire [31:0] qLow  = tRd + prodA[31:0];
  wire [63:0] qProd = qLow * mprime_r;
  wire [32:0] diff  = {1'b0, tRd} - {1'b0, mWord} - {32'h0, bw_r};
  wire        engWe = dEn && (eState_r == E_SUB || eState_r == E_COPY);
  wire [31:0] engDat = eState_r == E_COPY ? tRd : diff[31:0];
  wire        engDone = eState_r == E_FIN;
  wire        lastBit = bit_r == 12'h000;
  // the last bit still needs the conversion step, so only closing steps count
  wire        seqDone = engDone && (seq_r == S_OUT || seq_r == S_MM2 || mulOp);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mprime_r  <= 32'h0000_0000;
      mode_r    <= 7'h00;
      ct_r      <= bn_pkg::CTIME_RST;
      srchEn_r  <= bn_pkg::SRCHEN_RST;
      srchPos_r <= 12'h000;
      irqEn_r   <= bn_pkg::IRQEN_RST;
      date_r    <= bn_pkg::DATE_RST;
    end
    else
    begin
      if (hit(bn_pkg::OFF_MPRIME)) mprime_r <= merge(mprime_r);
      if (hit(bn_pkg::OFF_MODE)) mode_r <= 7'(merge(32'(mode_r)));
      if (hit(bn_pkg::OFF_CTIME)) ct_r <= bit0 | (ct_r & ~wbReq.sel[0]);
      if (hit(bn_pkg::OFF_SRCHEN)) srchEn_r <= bit0 | (srchEn_r & ~wbReq.sel[0]);
      if (hit(bn_pkg::OFF_SRCHPS)) srchPos_r <= 12'(merge(32'(srchPos_r)));
      if (hit(bn_pkg::OFF_IRQEN)) irqEn_r <= bit0 | (irqEn_r & ~wbReq.sel[0]);
      if (hit(bn_pkg::OFF_DATE)) date_r <= merge(date_r);
    end
  end

  // pending flag: a completion in the clear cycle wins
  always_ff @(posedge clk)
  begin
    if (srst)
      irqPend_r <= 1'b0;
    else
      irqPend_r <= seqDone | (irqPend_r & ~clrIrq);
  end
  assign irq = irqPend_r & irqEn_r;

  // ---------------------------------------------------------------
  // bus answer: ack one cycle after the request, data registered
  // ---------------------------------------------------------------
  always_comb
  begin
    rdNxt = 32'h0000_0000;
    if (isMem)
      rdNxt = memSel == bn_pkg::MEM_Z ? mem[bn_pkg::MEM_Z][memIdx] : 32'h0;
    else
      case (wbReq.adr)
        bn_pkg::OFF_MPRIME: rdNxt = mprime_r;
        bn_pkg::OFF_MODE:   rdNxt = {25'h0, mode_r};
        bn_pkg::OFF_CLEAN:  rdNxt = {31'h0, clean_r};
        bn_pkg::OFF_IDLE:   rdNxt = {31'h0, idle};
        bn_pkg::OFF_CTIME:  rdNxt = {31'h0, ct_r};
        bn_pkg::OFF_SRCHEN: rdNxt = {31'h0, srchEn_r};
        bn_pkg::OFF_SRCHPS: rdNxt = {20'h0, srchPos_r};
        bn_pkg::OFF_IRQEN:  rdNxt = {31'h0, irqEn_r};
        bn_pkg::OFF_DATE:   rdNxt = date_r;
        default:            rdNxt = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= access & ~ack_r;
      if (access & ~ack_r) rdat_r <= rdNxt;
    end
  end
  assign wbAck  = ack_r;
  assign wbDatR = rdat_r;

  // ---------------------------------------------------------------
  // operand memories and power-up clearing
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clrCnt_r <= 7'h00;
      clean_r  <= 1'b0;
    end
    else if (!clean_r)
    begin
      clrCnt_r <= clrCnt_r + 7'h01;
      clean_r  <= clrCnt_r == bn_pkg::CLR_LAST;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!clean_r)
    begin
      for (int k = 0; k < 4; k++) mem[k][clrCnt_r] <= 32'h0;
    end
    else if (engWe)
      mem[dMem][j_r[6:0]] <= engDat;
    else if (memWr)
      mem[memSel][memIdx] <= merge(mem[memSel][memIdx]);
  end

  // ---------------------------------------------------------------
  // step sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      seq_r <= S_IDLE;
      bit_r <= 12'h000;
    end
    else if (idle)
    begin
      if (goExp)
      begin
        seq_r <= S_XR;
        bit_r <= topBit;
      end
      else if (goMm)
        seq_r <= S_MM1;
      else if (goMul)
        seq_r <= S_PMUL;
    end
    else if (engDone)
    begin
      unique case (seq_r)
        S_XR:  seq_r <= S_ONE;
        S_ONE: seq_r <= S_SQ;
        S_SQ:
        begin
          if (bitY || ct_r)
            seq_r <= S_MUL;
          else if (lastBit)
            seq_r <= S_OUT;
          else
            bit_r <= bit_r - 12'h001;
        end
        S_MUL:
        begin
          if (lastBit)
            seq_r <= S_OUT;
          else
          begin
            seq_r <= S_SQ;
            bit_r <= bit_r - 12'h001;
          end
        end
        S_MM1:   seq_r <= S_MM2;
        default: seq_r <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // word-serial Montgomery / schoolbook engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      eState_r <= E_IDLE;
      i_r <= 8'h00;
      j_r <= 8'h00;
      q_r <= 32'h0;
      c_r <= 34'h0;
      bw_r <= 1'b0;
    end
    else
    begin
      unique case (eState_r)
        E_IDLE:
          if (seqOp)
          begin
            for (int k = 0; k <= bn_pkg::MEM_WORDS; k++) t[k] <= 32'h0;
            i_r <= 8'h00;
            j_r <= 8'h00;
            eState_r <= E_Q;
          end
        E_Q:
        begin
          q_r <= mulOp ? 32'h0 : qProd[31:0];
          c_r <= 34'h0;
          eState_r <= E_ROW;
        end
        E_ROW:
        begin
          if (mulOp || j_r != 8'h00) t[tWr] <= sum[31:0];
          c_r <= sum[65:32];
          j_r <= j_r + 8'h01;
          if (j_r == nLast) eState_r <= E_TAIL;
        end
        E_TAIL:
        begin
          t[tWr] <= tail[31:0];
          t[tWr + 8'h01] <= {30'h0, tail[33:32]};
          j_r <= 8'h00;
          bw_r <= 1'b0;
          if (i_r == nLast)
          begin
            i_r <= 8'h00;
            eState_r <= mulOp ? E_COPY : E_SUB;
          end
          else
          begin
            i_r <= i_r + 8'h01;
            eState_r <= E_Q;
          end
        end
        E_SUB:
        begin
          bw_r <= diff[32];
          j_r <= j_r + 8'h01;
          if (j_r == nLast) eState_r <= E_CHK;
        end
        E_CHK:
        begin
          j_r <= 8'h00;
          eState_r <= (tRd == 32'h0 && bw_r) ? E_COPY : E_FIN;
        end
        E_COPY:
        begin
          j_r <= j_r + 8'h01;
          if (j_r == copyLen - 8'h01) eState_r <= E_FIN;
        end
        E_FIN: eState_r <= E_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (access && !wbAck |=> wbAck)
    else $error("ack not one cycle after request");
  start_busy_a: assert property (goExp || goMm || goMul |=> !idle[*2])
    else $error("start did not leave idle");
  done_idle_a: assert property (seqDone |=> idle && irqPend_r)
    else $error("completion did not set idle and pending");
  irq_gate_a: assert property (seqDone && irqEn_r && !hit(bn_pkg::OFF_IRQEN) |=> irq)
    else $error("enabled completion gave no interrupt");
  irq_clear_a: assert property (clrIrq && !seqDone |=> !irqPend_r && !irq)
    else $error("clear did not drop interrupt");
  keep_mem_a: assert property (engWe |-> dMem == bn_pkg::MEM_Z
    || dMem == bn_pkg::MEM_X && seq_r == S_XR)
    else $error("engine wrote a preserved memory");
  keep_cfg_a: assert property (!idle && !wrHit |=> $stable(mode_r)
    && $stable(mprime_r))
    else $error("configuration changed by a job");
  len_bound_a: assert property (engWe |-> j_r < copyLen)
    else $error("write beyond operand length");
  skip_zero_a: assert property (engDone && seq_r == S_SQ && !ct_r && !bitY
    |=> seq_r != S_MUL)
    else $error("zero bit not skipped");
  clean_a: assert property (!clean_r && clrCnt_r == bn_pkg::CLR_LAST
    |=> clean_r)
    else $error("memory-ready not set after clearing");

  exp_done_c: cover property (seq_r == S_OUT && seqDone);
  mm_done_c: cover property (seq_r == S_MM2 && seqDone);
  mul_done_c: cover property (mulOp && seqDone);
  skip_c: cover property (engDone && seq_r == S_SQ && !ct_r && !bitY);
endmodule
`default_nettype wire

//--- test/test_big_number_modexp_accel.sv
`timescale 1ns/1ps
`default_nettype none
module test_big_number_modexp_accel;
  localparam logic [11:0] ZB   = 12'h200;
  localparam logic [11:0] YB   = 12'h400;
  localparam logic [11:0] XB   = 12'h600;
  localparam logic [31:0] MODV = 32'hF123_4567;
  localparam logic [31:0] XV   = 32'h1234_5678;
  localparam logic [31:0] YV   = 32'h0ABC_DEF1;
  localparam logic [31:0] EV   = 32'h0001_0001;
  localparam logic [31:0] PX   = 32'hFFFF_FFFF;
  localparam logic [31:0] PY   = 32'hFFFF_FFFE;
  localparam logic [11:0] RA [8] = '{bn_pkg::OFF_CTIME, bn_pkg::OFF_SRCHEN, bn_pkg::OFF_SRCHPS,
    bn_pkg::OFF_IRQEN, bn_pkg::OFF_MODE, bn_pkg::OFF_MPRIME, bn_pkg::OFF_DATE, bn_pkg::OFF_IDLE};
  localparam logic [31:0] RV [8] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h1, 32'h1};

  logic           clk;
  logic           srst;
  bn_pkg::wbReq_t wbReq;
  logic [31:0]    wbDatR;
  logic           wbAck;
  logic           irq;
  logic [31:0]    rd;
  int             errCount;
  int             nChecks;
  int             tick = 0;
  int             span0;
  int             span1;

  big_number_modexp_accel u_dut (
    .clk    (clk),
    .srst   (srst),
    .wbReq  (wbReq),
    .wbDatR (wbDatR),
    .wbAck  (wbAck),
    .irq    (irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) tick <= tick + 1;

  // ---------------------------------------------------------------
  // reference arithmetic, single-word operands only
  // ---------------------------------------------------------------
  function automatic logic [31:0] mulMod(input logic [31:0] a, input logic [31:0] b);
    return 32'((64'(a) * 64'(b)) % 64'(MODV));
  endfunction

  function automatic logic [31:0] powMod(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r = 32'h1;
    for (int i = 31; i >= 0; i--)
    begin
      r = mulMod(r, r);
      if (e[i]) r = mulMod(r, a);
    end
    return r;
  endfunction

  // negated inverse of the modulus, newton steps double the good bits
  function automatic logic [31:0] mPrime();
    logic [31:0] inv = MODV;
    repeat (5) inv = inv * (32'h2 - MODV * inv);
    return -inv;
  endfunction

  function automatic logic [31:0] rSq();
    return 32'((64'hFFFF_FFFF_FFFF_FFFF % 64'(MODV) + 64'h1) % 64'(MODV));
  endfunction

  // ---------------------------------------------------------------
  // bus access and checking
  // ---------------------------------------------------------------
  // no bound of its own: a missing ack is caught by the watchdog
  task automatic xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do
    begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatR;
    wbReq <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rdChk(input logic [11:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask

  task automatic waitIdle(output int span);
    int t0;
    t0 = tick;
    do
    begin
      xfer(1'b0, bn_pkg::OFF_IDLE, 32'h0);
    end while (rd[0] !== 1'b1);
    span = tick - t0;
  endtask

  task automatic irqChk(input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic results;
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    wbReq = '0;
    srst = 1'b1;
    errCount = 0;
    nChecks = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdChk(bn_pkg::OFF_CLEAN, 32'h0);
    waitIdle(span0);
    rd = 32'h0;
    for (int i = 0; i < 200 && rd[0] !== 1'b1; i++) xfer(1'b0, bn_pkg::OFF_CLEAN, 32'h0);
    chk(rd, 32'h1);
    for (int i = 0; i < 8; i++) rdChk(RA[i], RV[i]);
    chk({31'h0, irq}, 32'h0);
    wr(bn_pkg::OFF_MPRIME, 32'hFFFF_FFFF);
    rdChk(bn_pkg::OFF_MPRIME, 32'hFFFF_FFFF);
    wr(bn_pkg::OFF_MODE, 32'hFFFF_FFFF);
    rdChk(bn_pkg::OFF_MODE, 32'h7F);
    rdChk(12'h834, 32'h0);
    // junk above the configured length must not leak into results
    for (int i = 0; i < 4; i++) wr(12'(i * 512 + 4), 32'hDEAD_BEEF);
    wr(bn_pkg::OFF_MPRIME, mPrime());
    wr(bn_pkg::OFF_MODE, 32'h0);
    wr(12'h000, MODV);
    wr(XB, XV);
    wr(YB, YV);
    wr(ZB, rSq());
    wr(bn_pkg::OFF_MMGO, 32'h1);
    waitIdle(span0);
    rdChk(ZB, mulMod(XV, YV));
    irqChk(1'b1);
    wr(bn_pkg::OFF_IRQCLR, 32'h1);
    irqChk(1'b0);
    // only z reloaded: x, y and m must have survived
    wr(bn_pkg::OFF_IRQEN, 32'h0);
    wr(ZB, rSq());
    wr(bn_pkg::OFF_MMGO, 32'h1);
    waitIdle(span0);
    rdChk(ZB, mulMod(XV, YV));
    irqChk(1'b0);
    wr(bn_pkg::OFF_IRQEN, 32'h1);
    irqChk(1'b1);
    wr(bn_pkg::OFF_IRQCLR, 32'h1);
    wr(YB, EV);
    wr(ZB, rSq());
    wr(bn_pkg::OFF_EXPGO, 32'h1);
    rdChk(bn_pkg::OFF_IDLE, 32'h0);
    wr(bn_pkg::OFF_MULGO, 32'h1);
    waitIdle(span0);
    rdChk(ZB, powMod(XV, EV));
    rdChk(bn_pkg::OFF_MODE, 32'h0);
    rdChk(bn_pkg::OFF_MPRIME, mPrime());
    irqChk(1'b1);
    wr(bn_pkg::OFF_IRQCLR, 32'h1);
    wr(XB, XV);
    wr(ZB, rSq());
    wr(bn_pkg::OFF_CTIME, 32'h0);
    wr(bn_pkg::OFF_SRCHEN, 32'h1);
    wr(bn_pkg::OFF_SRCHPS, 32'h10);
    wr(bn_pkg::OFF_EXPGO, 32'h1);
    waitIdle(span1);
    rdChk(ZB, powMod(XV, EV));
    chk(32'(span1 < span0), 32'h1);
    wr(bn_pkg::OFF_CTIME, 32'h1);
    wr(bn_pkg::OFF_SRCHEN, 32'h0);
    wr(bn_pkg::OFF_IRQCLR, 32'h1);
    wr(bn_pkg::OFF_MODE, 32'h1);
    wr(XB, PX);
    wr(ZB + 12'h4, PY);
    wr(bn_pkg::OFF_MULGO, 32'h1);
    waitIdle(span0);
    rdChk(ZB, PX * PY);
    rdChk(ZB + 12'h4, 32'((64'(PX) * 64'(PY)) >> 32));
    rdChk(bn_pkg::OFF_MODE, 32'h1);
    results();
  end

  // a default exponentiation of one word stays far below this span
  initial
  begin
    repeat (40000) @(posedge clk);
    errCount++;
    results();
  end
endmodule
`default_nettype wire
